// ### dv/dfps_dram_model.sv
`timescale 1ns/10ps
`default_nettype none
module dfps_dram_model
  import dfps_pkg::*;
#(
  parameter logic [DATA_W-1:0] RD_PAT = 32'hc3a5_5a3c // read pattern
) (
  input  wire logic              i_clk,   // system clock
  input  wire logic [3:0]        i_cas_n, // column strobes
  input  wire logic              i_rw,    // 1 read
  output logic      [DATA_W-1:0] o_dq     // data toward controller
);
  logic [DATA_W-1:0] last_r = '0;
  // drive only under strobe
  // no pull on the bus: a floated line flips every cycle, never a stale match
  assign o_dq = (i_rw && i_cas_n != 4'hf) ? RD_PAT : ~last_r;
  always @(posedge i_clk) begin
    last_r <= o_dq;
  end
endmodule
`default_nettype wire

// ### dv/dfps_seq_props.sv
`timescale 1ns/10ps
`default_nettype none
module dfps_seq_props
  import dfps_pkg::*;
(
  input wire logic              i_clk,                     // system clock
  input wire logic              i_sys_rst,                 // sync reset
  input wire logic [1:0]        i_port_width,              // port width
  input wire logic [DATA_W-1:0] i_dq_in,                   // data bus in
  input wire logic              i_bus_grant_in,            // grant
  input wire logic              i_bus_lock_bit,            // lock
  input wire logic [1:0]        o_ras_n,                   // row strobes
  input wire logic [3:0]        o_cas_n,                   // column strobes
  input wire logic              o_dram_rw_select,          // 1 read
  input wire logic              o_transfer_start_strobe_n, // start strobe
  input wire logic [DATA_W-1:0] o_dq_out,                  // data out
  input wire logic              o_dq_oe,                   // data enable
  input wire logic              o_bus_driven_out_n,        // mastership
  input wire logic              o_transfer_acknowledge,    // acknowledge
  input wire logic [DATA_W-1:0] o_rdata,                   // read data
  input wire logic              o_rdata_valid              // read pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire strb = !o_transfer_start_strobe_n;
  wire ack  = o_transfer_acknowledge;
  wire rw   = o_dram_rw_select;
  property p_strb_pulse; strb |=> !strb; endproperty
  a_strb_pulse: assert property (p_strb_pulse)
    else $error("start strobe held too long");
  property p_wr_col; strb && !rw |=> o_dq_oe && o_cas_n != 4'hf ##1 ack; endproperty
  a_wr_col: assert property (p_wr_col)
    else $error("write column phase wrong");
  property p_rd_new; strb && rw && o_cas_n == 4'hf |=> o_cas_n != 4'hf ##1 ack; endproperty
  a_rd_new: assert property (p_rd_new)
    else $error("new page read length wrong");
  property p_rd_hit; strb && rw && o_cas_n != 4'hf |=> ack; endproperty
  a_rd_hit: assert property (p_rd_hit)
    else $error("page hit read length wrong");
  property p_ack_end; ack |=> !ack && o_cas_n == 4'hf; endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("transfer end wrong");
  property p_wr_rel; ack && !rw |=> !o_dq_oe; endproperty
  a_wr_rel: assert property (p_wr_rel)
    else $error("data bus not released");
  property p_rd_cap;
    ack && rw && i_port_width == PORT_32 |=> o_rdata_valid && o_rdata == $past(i_dq_in);
  endproperty
  a_rd_cap: assert property (p_rd_cap)
    else $error("read data capture wrong");
  property p_ras_fall; $fell(o_ras_n[0]) || $fell(o_ras_n[1]) |-> strb; endproperty
  a_ras_fall: assert property (p_ras_fall)
    else $error("row strobe fell outside start cycle");
  property p_lane16; o_dq_oe && i_port_width == PORT_16 |-> o_dq_out[15:0] == 16'h0; endproperty
  a_lane16: assert property (p_lane16)
    else $error("16-bit write not on upper lanes");
  property p_lock;
    i_bus_lock_bit && i_bus_grant_in && !o_bus_driven_out_n |=> !o_bus_driven_out_n;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked bus lost mastership");
endmodule
bind dfps_seq dfps_seq_props u_dfps_seq_props (.*);
`default_nettype wire

// ### dv/dfps_seq_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dfps_seq_tb;
  import dfps_pkg::*;
  localparam logic [DATA_W-1:0] PAT = 32'hc3a5_5a3c;
  typedef struct {
    logic wr, ext, bpm, bank, hit;
    logic [18:0] row;
    logic [1:0]  port, size, rp, ras;
    logic [3:0]  be;
    logic [31:0] wd;
    int          lat;
  } dfps_row_t;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_req = 1'b0, i_req_write = 1'b0, i_req_ext = 1'b0;
  logic i_req_bank = 1'b0, i_burst_page_mode = 1'b0, i_refresh_pending = 1'b0;
  logic i_bus_grant_in = 1'b1, i_bus_lock_bit = 1'b0, i_nondram_active = 1'b0;
  logic [ADDR_W-1:0] i_req_row = '0, i_req_col = '0, o_addr;
  logic [1:0] i_req_size = 2'h0, i_port_width = 2'h0, i_rp_cycles = 2'h1, i_cp_cycles = 2'h1;
  logic [1:0] o_ras_n, o_transfer_size_code;
  logic [3:0] i_req_be = 4'hf, o_cas_n;
  logic [DATA_W-1:0] i_wdata = '0, i_dq_in, o_dq_out, o_rdata;
  logic o_dram_rw_select, o_transfer_start_strobe_n, o_dq_oe, o_bus_oe;
  logic o_bus_driven_out_n, o_transfer_acknowledge, o_rdata_valid;
  int err_count = 0, checks = 0;
  dfps_row_t h;
  dfps_row_t tbl[8] = '{
    '{1, 0, 0, 0, 0, 19'h5, PORT_16, SIZE_WORD, 2'h1, 2'h2, 4'hf, 32'h1234, 3},
    '{1, 0, 0, 0, 1, 19'h5, PORT_16, SIZE_WORD, 2'h1, 2'h2, 4'hf, 32'hbeef, 3},
    '{0, 0, 0, 0, 1, 19'h5, PORT_16, SIZE_WORD, 2'h1, 2'h2, 4'hf, 32'h0, 2},
    '{0, 0, 0, 0, 0, 19'h9, PORT_8, SIZE_BYTE, 2'h2, 2'h2, 4'hf, 32'h0, 5},
    '{0, 0, 0, 1, 0, 19'h7, PORT_32, SIZE_LONG, 2'h1, 2'h1, 4'hf, 32'h0, 3},
    '{1, 1, 0, 1, 0, 19'h7, PORT_32, SIZE_WORD, 2'h1, 2'h3, 4'h3, 32'h5678, 4},
    '{0, 0, 1, 0, 0, 19'hb, PORT_16, SIZE_WORD, 2'h1, 2'h3, 4'hf, 32'h0, 3},
    '{1, 0, 0, 0, 0, 19'h4, PORT_8, SIZE_BYTE, 2'h1, 2'h2, 4'hf, 32'ha7, 3}};

  dfps_seq u_dfps_seq (.*);
  dfps_dram_model u_dfps_dram_model (.i_clk(i_clk), .i_cas_n(o_cas_n),
                                     .i_rw(o_dram_rw_select), .o_dq(i_dq_in));
  always #5 i_clk = ~i_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic run(input dfps_row_t r);
    int n;
    logic [3:0] cs;
    n = 0;
    cs = 4'hf;
    {i_req_write, i_req_ext, i_burst_page_mode, i_req_bank} = {r.wr, r.ext, r.bpm, r.bank};
    {i_req_row, i_req_col, i_port_width, i_req_size} = {r.row, r.row + 19'h100, r.port, r.size};
    {i_rp_cycles, i_req_be, i_wdata, i_req} = {r.rp, r.be, r.wd, 1'b1};
    while (o_transfer_acknowledge !== 1'b1 && n < 20) begin
      tick(1);
      n++;
      if (o_transfer_start_strobe_n === 1'b0) begin
        cmp("addr", r.hit ? r.row + 19'h100 : r.row, o_addr);
        cmp("rw", !r.wr, o_dram_rw_select);
        cmp("size", r.size, o_transfer_size_code);
      end
      if (o_cas_n !== 4'hf)
        cs = o_cas_n;
    end
    cmp("latency", r.lat, n);
    // cast keeps the inversion at four bits inside the 32-bit argument
    cmp("cas", r.port == PORT_8 ? 4'he : r.port == PORT_16 ? 4'hc : 4'(~r.be), cs);
    if (r.wr && r.port != PORT_32)
      cmp("dq", r.port == PORT_8 ? {r.wd[7:0], 24'h0} : {r.wd[15:0], 16'h0}, o_dq_out);
    tick(1);
    i_req = 1'b0;
    cmp("end", {6'h1e, r.ras, !r.wr}, {o_transfer_acknowledge, o_cas_n, o_dq_oe, o_ras_n,
        o_rdata_valid});
    if (!r.wr)
      cmp("rdata", r.port == PORT_8 ? {24'h0, PAT[31:24]} :
          r.port == PORT_16 ? {16'h0, PAT[31:16]} : PAT, o_rdata);
    tick(3);
  endtask

  task automatic regain();
    i_bus_grant_in = 1'b1;
    tick(2);
    cmp("regain", 2'h1, {o_bus_driven_out_n, o_bus_oe});
  endtask

  initial begin
    #20us;
    err_count++;
    end_of_test();
  end

  initial begin
    tick(12);
    cmp("reset", 9'h1fd, {o_ras_n, o_cas_n, o_transfer_start_strobe_n,
        o_transfer_acknowledge, o_bus_driven_out_n});
    i_sys_rst = 1'b0;
    tick(2);
    foreach (tbl[i]) run(tbl[i]);
    h = tbl[7];
    h.hit = 1'b1;
    h.ras = 2'h3;
    fork
      run(h);
      begin
        tick(1);
        i_bus_grant_in = 1'b0;
        tick(1);
        cmp("drv busy", 1'b0, o_bus_driven_out_n);
      end
    join
    cmp("drv end", 1'b1, o_bus_driven_out_n);
    regain();
    run(tbl[7]);
    // grant removed after three idle clocks
    i_bus_grant_in = 1'b0;
    tick(1);
    cmp("idle loss", 4'hb, {o_bus_driven_out_n, o_bus_oe, o_ras_n});
    regain();
    run(tbl[7]);
    i_nondram_active = 1'b1;
    i_bus_grant_in = 1'b0;
    tick(1);
    cmp("nondram", 3'h3, {o_bus_driven_out_n, o_ras_n});
    i_nondram_active = 1'b0;
    tick(1);
    cmp("nondram drv", 1'b1, o_bus_driven_out_n);
    regain();
    run(tbl[7]);
    i_bus_lock_bit = 1'b1;
    tick(1);
    i_bus_grant_in = 1'b0;
    tick(3);
    cmp("locked", 3'h2, {o_bus_driven_out_n, o_ras_n});
    i_bus_grant_in = 1'b1;
    i_bus_lock_bit = 1'b0;
    i_refresh_pending = 1'b1;
    tick(2);
    cmp("refresh", 2'h3, o_ras_n);
    end_of_test();
  end
endmodule
`default_nettype wire

// ### rtl/dfps_page_track.sv
`timescale 1ns/10ps
`default_nettype none
module dfps_page_track
  import dfps_pkg::*;
(
  input  wire logic i_clk,     // system clock
  input  wire logic i_sys_rst, // sync reset
  dfps_trk_if.trk   trk        // lookup and update port
);
  logic [ADDR_W-1:0] tag_r   [2];
  logic [ADDR_W-1:0] tag_nxt [2];
  logic [1:0]        vld_r;
  logic [1:0]        vld_nxt;

  always_comb begin
    vld_nxt = vld_r & ~trk.close_en;
    tag_nxt = tag_r;
    if (trk.open_en) begin
      vld_nxt[trk.open_bank] = 1'b1;
      tag_nxt[trk.open_bank] = trk.open_row;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      vld_r      <= 2'h0;
      tag_r[0]   <= '0;
      tag_r[1]   <= '0;
    end else begin
      vld_r      <= vld_nxt;
      tag_r      <= tag_nxt;
    end
  end

  assign trk.valid = vld_r;
  assign trk.hit   = vld_r[trk.lk_bank] && (tag_r[trk.lk_bank] == trk.lk_row);
endmodule
`default_nettype wire

// ### rtl/dfps_pkg.sv
package dfps_pkg;
  localparam int          ADDR_W     = 19;
  localparam int          DATA_W     = 32;
  localparam int          CNT_W      = 3;
  // transfer size codes
  localparam logic [1:0]  SIZE_LONG  = 2'h0;
  localparam logic [1:0]  SIZE_BYTE  = 2'h1;
  localparam logic [1:0]  SIZE_WORD  = 2'h2;
  // bank port width codes
  localparam logic [1:0]  PORT_32    = 2'h0;
  localparam logic [1:0]  PORT_8     = 2'h1;
  localparam logic [1:0]  PORT_16    = 2'h2;
  localparam logic        RW_WRITE   = 1'b0;
  localparam logic        RW_READ    = 1'b1;
  localparam logic [3:0]  CAS_16     = 4'h3;
  localparam logic [3:0]  CAS_8      = 4'h1;
  // reset values of the pin registers
  localparam logic [1:0]  RAS_N_RST  = 2'h3;
  localparam logic [3:0]  CAS_N_RST  = 4'hf;
  localparam logic        STRB_N_RST = 1'b1;
  localparam logic        DRV_N_RST  = 1'b1;
  // fastest precharge, in clocks
  localparam logic [1:0]  RP_MIN_CYC = 2'h1;
  localparam logic [1:0]  CP_MIN_CYC = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_ROW, ST_HCOLW, ST_HCOLR, ST_COL, ST_ACK
  } dfps_state_t;

  function automatic logic [1:0] bank_bit(input logic b);
    bank_bit = b ? 2'h2 : 2'h1;
  endfunction

  function automatic logic [3:0] cas_sel(input logic [1:0] port, input logic [3:0] be);
    case (port)
      PORT_8:  cas_sel = CAS_8;
      PORT_16: cas_sel = CAS_16;
      default: cas_sel = be;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] clamp_cnt(input logic [1:0] n, input logic [1:0] lo,
                                                 input logic minus1);
    logic [1:0] v;
    v = (n < lo) ? lo : n;
    clamp_cnt = {1'b0, v} - {2'b00, minus1};
  endfunction
endpackage

// ### rtl/dfps_prech_timer.sv
`timescale 1ns/10ps
`default_nettype none
module dfps_prech_timer
  import dfps_pkg::*;
(
  input  wire logic             i_clk,     // system clock
  input  wire logic             i_sys_rst, // sync reset
  input  wire logic             i_load,    // start precharge
  input  wire logic [CNT_W-1:0] i_val,     // clocks still to wait
  output logic                  o_ready    // precharge met
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_ready = (cnt_r == '0);
endmodule
`default_nettype wire

// ### rtl/dfps_seq.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - new-page write cycle one: row address, write select, word size, start strobe
// - row strobe asserts in the low phase of the first new-page cycle
// - second cycle: start strobe off, column address, write data on upper lanes
// - next low phase: column strobes by port width and byte lanes
// - acknowledge one clock before the transfer ends
// - at end drop acknowledge and column strobes, keep row strobe open
// - release the whole data bus after a write completes
// - page-hit write: column address with start, data next, strobes after
// - page miss waits row precharge then runs a full new-page transfer
// - other bank already precharged, so start without delay
// - byte read from 8-bit port: read select, byte size, lowest strobe
// - read data captured on the edge after the acknowledge clock
// - page miss drops row strobe next clock, starts after precharge
// - page-miss reads and writes share the same timing
// - losing mastership with a page open precharges the row strobe
// - unlocked grant loss in a DRAM transfer: finish, then release, precharge
// - unlocked grant loss in non-DRAM transfer: precharge next cycle, hold bus
// - unlocked grant loss while idle: release bus, precharge, next cycle
// - locked bus keeps mastership and open page when grant drops
// - external-master transfers behave as burst page mode
// - transfer to the other bank closes the open page
// - pending refresh closes the open page
// - burst page mode closes the page when the transfer ends
module dfps_seq
  import dfps_pkg::*;
(
  input  wire logic              i_clk,                   // system clock
  input  wire logic              i_sys_rst,               // sync reset
  input  wire logic              i_req,                   // transfer request, held
  input  wire logic              i_req_write,             // 1 write, 0 read
  input  wire logic              i_req_ext,               // external master request
  input  wire logic              i_req_bank,              // target bank
  input  wire logic [ADDR_W-1:0] i_req_row,               // row address
  input  wire logic [ADDR_W-1:0] i_req_col,               // column address
  input  wire logic [1:0]        i_req_size,              // size code
  input  wire logic [3:0]        i_req_be,                // byte lanes, 32-bit port
  input  wire logic [1:0]        i_port_width,            // bank port width
  input  wire logic              i_burst_page_mode,       // bank in burst page mode
  input  wire logic [DATA_W-1:0] i_wdata,                 // write data, low aligned
  input  wire logic [1:0]        i_rp_cycles,             // row precharge clocks
  input  wire logic [1:0]        i_cp_cycles,             // column precharge clocks
  input  wire logic              i_refresh_pending,       // refresh wants the bank
  input  wire logic              i_bus_grant_in,          // arbiter grant
  input  wire logic              i_bus_lock_bit,          // lock bus once granted
  input  wire logic              i_nondram_active,        // other bus transfer running
  input  wire logic [DATA_W-1:0] i_dq_in,                 // data bus in
  output logic [ADDR_W-1:0]      o_addr,                  // muxed row/column address
  output logic [1:0]             o_ras_n,                 // row strobes per bank
  output logic [3:0]             o_cas_n,                 // column strobes
  output logic                   o_dram_rw_select,        // 1 read, 0 write
  output logic [1:0]             o_transfer_size_code,    // size code
  output logic                   o_transfer_start_strobe_n, // start strobe
  output logic [DATA_W-1:0]      o_dq_out,                // data bus out
  output logic                   o_dq_oe,                 // data bus enable
  output logic                   o_bus_oe,                // bus control enable
  output logic                   o_bus_driven_out_n,      // mastership held
  output logic                   o_transfer_acknowledge,  // internal acknowledge
  output logic [DATA_W-1:0]      o_rdata,                 // captured read data
  output logic                   o_rdata_valid            // read data pulse
);
  dfps_trk_if trk ();

  dfps_state_t        st_r, st_nxt;
  logic               owner_r, owner_nxt;
  logic               locked_r, locked_nxt;
  logic               cw_r, cw_nxt;
  logic               cb_r, cb_nxt;
  logic               ccl_r, ccl_nxt;
  logic [ADDR_W-1:0]  crow_r, crow_nxt;
  logic [ADDR_W-1:0]  ccol_r, ccol_nxt;
  logic [1:0]         csz_r, csz_nxt;
  logic [1:0]         cport_r, cport_nxt;
  logic [3:0]         cbe_r, cbe_nxt;
  logic [DATA_W-1:0]  cwd_r, cwd_nxt;

  logic [ADDR_W-1:0]  addr_nxt;
  logic [1:0]         ras_n_nxt;
  logic [3:0]         cas_n_nxt;
  logic               rw_nxt;
  logic [1:0]         sz_nxt;
  logic               strb_n_nxt;
  logic [DATA_W-1:0]  dq_nxt;
  logic               dq_oe_nxt;
  logic               ack_nxt;
  logic [DATA_W-1:0]  rdata_nxt;
  logic               rvld_nxt;

  logic [1:0]         close;
  logic               open_en;
  logic               lose;
  logic               cas_load;
  logic               cas_rdy;
  logic [1:0]         ras_rdy;
  logic [CNT_W-1:0]   rp_val;
  logic [CNT_W-1:0]   cp_val;

  assign rp_val = clamp_cnt(i_rp_cycles, RP_MIN_CYC, 1'b1);
  assign cp_val = clamp_cnt(i_cp_cycles, CP_MIN_CYC, 1'b0);

  dfps_page_track u_trk (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .trk       (trk.trk)
  );

  dfps_prech_timer u_cas_tmr (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    (cas_load),
    .i_val     (cp_val),
    .o_ready   (cas_rdy)
  );

  // one row precharge timer per bank, so the idle bank never waits on the other bank's precharge
  for (genvar b = 0; b < 2; b++) begin : g_ras
    dfps_prech_timer u_ras_tmr (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_load    (close[b]),
      .i_val     (rp_val),
      .o_ready   (ras_rdy[b])
    );
  end

  assign trk.lk_bank  = i_req_bank;
  assign trk.lk_row   = i_req_row;
  assign trk.open_en  = open_en;
  assign trk.open_bank = cb_nxt;
  assign trk.open_row = crow_nxt;
  assign trk.close_en = close;

  assign locked_nxt = i_bus_lock_bit && (locked_r || i_bus_grant_in);
  assign lose = owner_r && !i_bus_grant_in && !locked_r;

  // sequencing and mastership
  always_comb begin
    st_nxt    = st_r;
    owner_nxt = owner_r;
    cw_nxt    = cw_r;
    cb_nxt    = cb_r;
    ccl_nxt   = ccl_r;
    crow_nxt  = crow_r;
    ccol_nxt  = ccol_r;
    csz_nxt   = csz_r;
    cport_nxt = cport_r;
    cbe_nxt   = cbe_r;
    cwd_nxt   = cwd_r;
    close     = 2'h0;
    open_en   = 1'b0;
    cas_load  = 1'b0;
    rdata_nxt = o_rdata;
    rvld_nxt  = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (!owner_r) begin
          if (i_bus_grant_in && !i_nondram_active) begin
            owner_nxt = 1'b1;
          end
        end else if (lose) begin
          close = trk.valid;
          if (!i_nondram_active) begin
            owner_nxt = 1'b0;
          end
        end else if (i_refresh_pending) begin
          close = trk.valid;
        end else if (i_req && !i_nondram_active) begin
          cw_nxt    = i_req_write;
          cb_nxt    = i_req_bank;
          ccl_nxt   = i_req_ext || i_burst_page_mode;
          crow_nxt  = i_req_row;
          ccol_nxt  = i_req_col;
          csz_nxt   = i_req_size;
          cport_nxt = i_port_width;
          cbe_nxt   = i_req_be;
          cwd_nxt   = i_wdata;
          if (trk.hit && !i_req_ext) begin
            if (cas_rdy) begin
              st_nxt = i_req_write ? ST_HCOLW : ST_HCOLR;
            end
          end else if (trk.valid[i_req_bank]) begin
            // same path for reads and writes
            close  = bank_bit(i_req_bank);
            st_nxt = ST_PRE;
          end else if (ras_rdy[i_req_bank]) begin
            close   = trk.valid & ~bank_bit(i_req_bank);
            open_en = 1'b1;
            st_nxt  = ST_ROW;
          end
        end
      end
      ST_PRE: begin
        if (ras_rdy[cb_r]) begin
          open_en = 1'b1;
          st_nxt  = ST_ROW;
        end
      end
      ST_ROW: begin
        st_nxt = ST_COL;
      end
      ST_HCOLW: begin
        st_nxt = ST_COL;
      end
      ST_HCOLR: begin
        st_nxt = ST_ACK;
      end
      ST_COL: begin
        st_nxt = ST_ACK;
      end
      ST_ACK: begin
        st_nxt   = ST_IDLE;
        cas_load = 1'b1;
        if (!cw_r) begin
          rdata_nxt = lane_take(cport_r, i_dq_in);
          rvld_nxt  = 1'b1;
        end
        if (lose) begin
          close     = trk.valid;
          owner_nxt = 1'b0;
        end else if (ccl_r || i_refresh_pending) begin
          close = bank_bit(cb_r);
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  function automatic logic [DATA_W-1:0] lane_take(input logic [1:0] port,
                                                  input logic [DATA_W-1:0] dq);
    case (port)
      PORT_8:  lane_take = {24'h000000, dq[31:24]};
      PORT_16: lane_take = {16'h0000, dq[31:16]};
      default: lane_take = dq;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] lane_put(input logic [1:0] port,
                                                 input logic [DATA_W-1:0] wd);
    case (port)
      PORT_8:  lane_put = {wd[7:0], 24'h000000};
      PORT_16: lane_put = {wd[15:0], 16'h0000};
      default: lane_put = wd;
    endcase
  endfunction

  // pin values for the cycle being entered; strobes marked for the low
  // phase are shown for the whole cycle, the half-clock skew is in the pad
  always_comb begin
    addr_nxt  = o_addr;
    rw_nxt    = cw_nxt ? RW_WRITE : RW_READ;
    sz_nxt    = csz_nxt;
    strb_n_nxt = 1'b1;
    cas_n_nxt = CAS_N_RST;
    dq_nxt    = o_dq_out;
    dq_oe_nxt = 1'b0;
    ack_nxt   = 1'b0;
    ras_n_nxt = ~((trk.valid & ~close) | (open_en ? bank_bit(cb_nxt) : 2'h0));
    case (st_nxt)
      ST_ROW: begin
        addr_nxt = crow_nxt;
        strb_n_nxt = 1'b0;
      end
      ST_HCOLW: begin
        addr_nxt = ccol_nxt;
        strb_n_nxt = 1'b0;
      end
      ST_HCOLR: begin
        addr_nxt  = ccol_nxt;
        strb_n_nxt = 1'b0;
        cas_n_nxt = ~cas_sel(cport_nxt, cbe_nxt);
      end
      ST_COL: begin
        addr_nxt  = ccol_nxt;
        cas_n_nxt = ~cas_sel(cport_nxt, cbe_nxt);
        dq_nxt    = lane_put(cport_nxt, cwd_nxt);
        dq_oe_nxt = cw_nxt;
      end
      ST_ACK: begin
        ack_nxt   = 1'b1;
        cas_n_nxt = o_cas_n;
        dq_oe_nxt = o_dq_oe;
      end
      default: begin
        strb_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r                      <= ST_IDLE;
      owner_r                   <= 1'b0;
      locked_r                  <= 1'b0;
      cw_r                      <= 1'b0;
      cb_r                      <= 1'b0;
      ccl_r                     <= 1'b0;
      crow_r                    <= '0;
      ccol_r                    <= '0;
      csz_r                     <= SIZE_LONG;
      cport_r                   <= PORT_32;
      cbe_r                     <= 4'h0;
      cwd_r                     <= '0;
      o_addr                    <= '0;
      o_ras_n                   <= RAS_N_RST;
      o_cas_n                   <= CAS_N_RST;
      o_dram_rw_select          <= RW_READ;
      o_transfer_size_code      <= SIZE_LONG;
      o_transfer_start_strobe_n <= STRB_N_RST;
      o_dq_out                  <= '0;
      o_dq_oe                   <= 1'b0;
      o_bus_oe                  <= 1'b0;
      o_bus_driven_out_n        <= DRV_N_RST;
      o_transfer_acknowledge    <= 1'b0;
      o_rdata                   <= '0;
      o_rdata_valid             <= 1'b0;
    end else begin
      st_r                      <= st_nxt;
      owner_r                   <= owner_nxt;
      locked_r                  <= locked_nxt;
      cw_r                      <= cw_nxt;
      cb_r                      <= cb_nxt;
      ccl_r                     <= ccl_nxt;
      crow_r                    <= crow_nxt;
      ccol_r                    <= ccol_nxt;
      csz_r                     <= csz_nxt;
      cport_r                   <= cport_nxt;
      cbe_r                     <= cbe_nxt;
      cwd_r                     <= cwd_nxt;
      o_addr                    <= addr_nxt;
      o_ras_n                   <= ras_n_nxt;
      o_cas_n                   <= cas_n_nxt;
      o_dram_rw_select          <= rw_nxt;
      o_transfer_size_code      <= sz_nxt;
      o_transfer_start_strobe_n <= strb_n_nxt;
      o_dq_out                  <= dq_nxt;
      o_dq_oe                   <= dq_oe_nxt;
      o_bus_oe                  <= owner_nxt;
      o_bus_driven_out_n        <= ~owner_nxt;
      o_transfer_acknowledge    <= ack_nxt;
      o_rdata                   <= rdata_nxt;
      o_rdata_valid             <= rvld_nxt;
    end
  end
endmodule
`default_nettype wire

// ### rtl/dfps_trk_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dfps_trk_if;
  logic [1:0]  valid;
  logic        hit;
  logic        lk_bank;
  logic [18:0] lk_row;
  logic        open_en;
  logic        open_bank;
  logic [18:0] open_row;
  logic [1:0]  close_en;
  modport ctl (output lk_bank, lk_row, open_en, open_bank, open_row, close_en,
               input valid, hit);
  modport trk (input lk_bank, lk_row, open_en, open_bank, open_row, close_en,
               output valid, hit);
endinterface
`default_nettype wire
